// File: rcwe_defines.vh
`ifndef RCWE_DEFINES_VH
`define RCWE_DEFINES_VH
// register byte addresses
`define RCWE_ADDR_RCC 4'h0
`define RCWE_ADDR_CFG 4'h4
`define RCWE_ADDR_STAT 4'h8
`define RCWE_ADDR_CMD 4'hC
// reset cause/control bit positions
`define RCWE_BIT_PRIO 7
`define RCWE_BIT_SBOR 6
`define RCWE_BIT_SWRST 4
`define RCWE_BIT_TO 3
`define RCWE_BIT_PDOWN 2
`define RCWE_BIT_POR 1
`define RCWE_BIT_BROWN 0
// writable mask of the reset cause/control register
`define RCWE_RCC_WMASK 8'hD3
// oscillator mode codes (cfg bits 3:0)
`define RCWE_OSC_LOWPWR 4'h0
`define RCWE_OSC_STDXTAL 4'h1
`define RCWE_OSC_FASTXTAL 4'h2
`define RCWE_OSC_PLL 4'h3
`define RCWE_OSC_EXTCLK 4'h4
`define RCWE_OSC_RCNET 4'h5
`define RCWE_OSC_INT 4'h6
// prior clock codes on a wake
`define RCWE_PRI_PRIMARY 2'h0
`define RCWE_PRI_SEC 2'h1
`define RCWE_PRI_INT 2'h2
`define RCWE_PRI_NONE 2'h3
// brown-out mode for software control
`define RCWE_BROWN_SOFT 2'h1
// default internal oscillator frequency select
`define RCWE_IRCF_DEF 3'h4
// timing: clock in kHz, delays in ns
`define RCWE_CLK_KHZ 25000
`define RCWE_TCSD_NS 2000
`define RCWE_TSTART_NS 40960
`define RCWE_TPLL_NS 2000000
`define RCWE_FILT_CYC 8
`endif

// File: rcwe_sync_filter.v
`timescale 1ns/10ps
// three-stage synchroniser and low-level qualifier for the reset pin
module rcwe_sync_filter #(
  parameter MIN_CYC = 8
) (
  // clock and reset
  input wire clk_i,
  input wire arst_n_i,
  // pin and qualified result
  input wire pin_i,
  output reg qual_low_o,
  output wire level_o
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  reg [15:0] cnt_r;
  // stable level once the second and third stages agree
  reg stab_r;
  assign level_o = stab_r;
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      stab_r <= 1'b1;
    end else begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        stab_r <= s3_r;
      end
    end
  end
  // count low cycles; short pulses never reach the limit
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_r <= 16'h0000;
      qual_low_o <= 1'b0;
    end else if (stab_r) begin
      cnt_r <= 16'h0000;
      qual_low_o <= 1'b0;
    end else if (cnt_r < MIN_CYC[15:0] - 16'h0001) begin
      cnt_r <= cnt_r + 16'h0001;
    end else begin
      qual_low_o <= 1'b1;
    end
  end
endmodule

// File: rcwe_top.v
`timescale 1ns/10ps
`include "rcwe_defines.vh"
// Notes on behaviour
// RULE1: no start-up timer on wake unless primary is a crystal mode.
// RULE2: wake from primary idle uses only the CPU wake delay.
// RULE3: after any wake, wait CPU delay, then start execution next cycle.
// RULE4: CPU wake delay runs alongside other delays, not after them.
// RULE5: exit delay chosen from prior clock and target clock kind.
// RULE6: readiness via primary-ready bit, or internal-stable for internal.
// RULE7: internal oscillator target covers base and postscaled frequencies.
// RULE8: any reset returns internal oscillator frequency select to default.
// RULE9: eight reset causes are distinguished.
// RULE10: software-reset, power-on, brown-out flags cleared by event, set by software; watchdog and power-down flags ignore writes, set by hardware.
// RULE11: priority-enable bit is read/write, selects two priority levels.
// RULE12: brown-out soft enable works only in mode 01, else reads 0.
// RULE13: brown-out soft enable resets to 1 in mode 01, else 0.
// RULE14: software-reset flag cleared by reset instruction, set by firmware.
// RULE15: watchdog flag read-only; set by power-up, clear, sleep; cleared on timeout.
// RULE16: power-down flag read-only; set by power-up or clear; cleared by sleep.
// RULE17: power-on flag cleared on power-on reset only, never set by hardware.
// RULE18: brown-out flag cleared on brown-out reset, set only by firmware.
// RULE19: software reads brown-out 0 with power-on 1 as brown-out reset.
// RULE20: software should set power-on flag after a power-on reset.
// RULE21: holding reset pin low resets device; short noise pulses filtered.
// RULE22: internal resets never drive the reset pin.
// RULE23: with pin function disabled, pin is plain digital input.
// RULE24: pin filter is synchronised low qualifier with parameter length.
module rcwe_top #(
  parameter FILT_CYC = `RCWE_FILT_CYC,
  parameter PLL_CYC = (`RCWE_TPLL_NS / 1000) * (`RCWE_CLK_KHZ / 1000)
) (
  // clock and reset (power-on)
  input wire clk_i,
  input wire arst_n_i,
  // configuration straps
  input wire [1:0] brownout_mode_config_i,
  input wire master_reset_pin_enable_i,
  // reset pin and event sources
  input wire master_reset_pin_i,
  input wire brownout_evt_i,
  input wire wdt_reset_evt_i,
  input wire wdt_timeout_evt_i,
  input wire reset_instr_evt_i,
  input wire stack_full_evt_i,
  input wire stack_under_evt_i,
  input wire sleep_instr_i,
  input wire watchdog_clear_instr_i,
  input wire pm_mode_i,
  // wake request
  input wire wake_i,
  input wire [1:0] wake_prior_i,
  // reset pin outputs
  output wire master_reset_pin_o,
  output wire master_reset_pin_oe_o,
  output wire pin_digital_o,
  // reset and run status
  output reg dev_reset_o,
  output reg [3:0] reset_cause_o,
  output reg cpu_run_o,
  output reg primary_clock_ready_o,
  output reg internal_osc_stable_o,
  output wire irq_priority_enable_o,
  output wire brownout_enabled_o,
  output reg [2:0] ircf_o,
  // axi4-lite slave
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  localparam CSD_CYC = (`RCWE_TCSD_NS * (`RCWE_CLK_KHZ / 1000) + 999) / 1000;
  localparam START_CYC =
    (`RCWE_TSTART_NS * (`RCWE_CLK_KHZ / 1000) + 999) / 1000;
  localparam ST_RUN = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_GO = 3'b100;
  // cause codes
  localparam [3:0] C_NONE = 4'h0;
  localparam [3:0] C_POR = 4'h1;
  localparam [3:0] C_PIN_RUN = 4'h2;
  localparam [3:0] C_PIN_PM = 4'h3;
  localparam [3:0] C_WDT = 4'h4;
  localparam [3:0] C_BROWN = 4'h5;
  localparam [3:0] C_INSTR = 4'h6;
  localparam [3:0] C_STK_FULL = 4'h7;
  localparam [3:0] C_STK_UNDER = 4'h8;

  wire pin_low;
  wire pin_level;
  reg por_pend_r;
  reg prio_en_r;
  reg bo_soft_r;
  reg swrst_r;
  reg to_r;
  reg pdown_r;
  reg por_r;
  reg brown_r;
  reg [3:0] osc_mode_r;
  reg [2:0] st_r;
  reg [2:0] st_nxt;
  reg [23:0] csd_cnt_r;
  reg [23:0] osc_cnt_r;
  reg start_need_r;
  reg pin_rst;
  reg any_rst;

  // pin filter RULE24
  rcwe_sync_filter #(
    .MIN_CYC(FILT_CYC)
  ) u_filt (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .pin_i(master_reset_pin_i),
    .qual_low_o(pin_low),
    .level_o(pin_level)
  );

  // pin is never driven by the block RULE22
  assign master_reset_pin_o = 1'b0;
  assign master_reset_pin_oe_o = 1'b0;
  // digital input when reset function is off RULE23
  assign pin_digital_o = master_reset_pin_enable_i ? 1'b1 : pin_level;

  // reset events from all sources RULE21
  always @* begin
    pin_rst = master_reset_pin_enable_i & pin_low;
    any_rst = pin_rst | brownout_evt_i | wdt_reset_evt_i | reset_instr_evt_i |
              stack_full_evt_i | stack_under_evt_i;
  end

  // reset cause register and reset output RULE9
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reset_cause_o <= C_POR;
      dev_reset_o <= 1'b1;
      por_pend_r <= 1'b1;
    end else begin
      por_pend_r <= 1'b0;
      dev_reset_o <= any_rst;
      if (pin_rst) begin
        reset_cause_o <= pm_mode_i ? C_PIN_PM : C_PIN_RUN;
      end else if (brownout_evt_i) begin
        reset_cause_o <= C_BROWN;
      end else if (wdt_reset_evt_i) begin
        reset_cause_o <= C_WDT;
      end else if (reset_instr_evt_i) begin
        reset_cause_o <= C_INSTR;
      end else if (stack_full_evt_i) begin
        reset_cause_o <= C_STK_FULL;
      end else if (stack_under_evt_i) begin
        reset_cause_o <= C_STK_UNDER;
      end
    end
  end

  // axi handshakes: write when both address and data present
  wire wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  wire rd_go = s_axi_arvalid & ~s_axi_rvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = rd_go;
  wire wr_rcc = wr_go & (s_axi_awaddr == `RCWE_ADDR_RCC) & s_axi_wstrb[0];
  wire wr_cfg = wr_go & (s_axi_awaddr == `RCWE_ADDR_CFG) & s_axi_wstrb[0];
  wire [7:0] wd = s_axi_wdata[7:0];
  wire soft_mode = (brownout_mode_config_i == `RCWE_BROWN_SOFT);

  // write response: okay on RCC and CFG, slverr on any other address
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (s_axi_awaddr == `RCWE_ADDR_RCC ||
                      s_axi_awaddr == `RCWE_ADDR_CFG) ? 2'h0 : 2'h2;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // reset cause/control flags; event clear wins over a write RULE10
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prio_en_r <= 1'b0;
      bo_soft_r <= 1'b0;
      swrst_r <= 1'b1;
      to_r <= 1'b1;
      pdown_r <= 1'b1;
      por_r <= 1'b0;
      brown_r <= 1'b0;
    end else begin
      if (por_pend_r) begin
        bo_soft_r <= soft_mode; // RULE13
      end else if (wr_rcc) begin
        bo_soft_r <= wd[`RCWE_BIT_SBOR];
      end
      if (wr_rcc) begin
        prio_en_r <= wd[`RCWE_BIT_PRIO]; // RULE11
        por_r <= wd[`RCWE_BIT_POR] | por_r; // RULE17
      end
      // instruction reset clears, firmware sets RULE14
      if (reset_instr_evt_i) begin
        swrst_r <= 1'b0;
      end else if (wr_rcc) begin
        swrst_r <= wd[`RCWE_BIT_SWRST];
      end
      // brown-out clears, firmware sets RULE18
      if (brownout_evt_i) begin
        brown_r <= 1'b0;
      end else if (wr_rcc) begin
        brown_r <= wd[`RCWE_BIT_BROWN];
      end
      // watchdog flag RULE15
      if (wdt_timeout_evt_i | wdt_reset_evt_i) begin
        to_r <= 1'b0;
      end else if (watchdog_clear_instr_i | sleep_instr_i) begin
        to_r <= 1'b1;
      end
      // power-down flag RULE16
      if (sleep_instr_i) begin
        pdown_r <= 1'b0;
      end else if (watchdog_clear_instr_i) begin
        pdown_r <= 1'b1;
      end
    end
  end

  // soft enable only in mode 01 RULE12
  wire bo_soft_eff = soft_mode & bo_soft_r;
  assign brownout_enabled_o = (brownout_mode_config_i == 2'h0) ? 1'b0 :
                              soft_mode ? bo_soft_r : 1'b1;
  assign irq_priority_enable_o = prio_en_r;
  wire [7:0] rcc_val = {prio_en_r, bo_soft_eff, 1'b0, swrst_r, to_r,
                        pdown_r, por_r, brown_r};

  // configuration: oscillator mode and frequency select
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      osc_mode_r <= `RCWE_OSC_FASTXTAL;
      ircf_o <= `RCWE_IRCF_DEF;
    end else if (any_rst) begin
      ircf_o <= `RCWE_IRCF_DEF; // RULE8
    end else if (wr_cfg) begin
      osc_mode_r <= wd[3:0];
      ircf_o <= wd[6:4]; // RULE7
    end
  end

  // read data path
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      case (s_axi_araddr)
        `RCWE_ADDR_RCC: s_axi_rdata <= {24'h000000, rcc_val};
        `RCWE_ADDR_CFG: s_axi_rdata <= {25'h0000000, ircf_o, osc_mode_r};
        `RCWE_ADDR_STAT: s_axi_rdata <= {24'h000000, reset_cause_o,
                                         internal_osc_stable_o,
                                         primary_clock_ready_o,
                                         cpu_run_o, dev_reset_o};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // target clock classes RULE1
  wire tgt_xtal = (osc_mode_r == `RCWE_OSC_LOWPWR) |
                  (osc_mode_r == `RCWE_OSC_STDXTAL) |
                  (osc_mode_r == `RCWE_OSC_FASTXTAL) |
                  (osc_mode_r == `RCWE_OSC_PLL);
  wire tgt_int = (osc_mode_r == `RCWE_OSC_INT);
  // start-up timer needed only for crystal, not from primary idle RULE5
  wire start_need = tgt_xtal & (wake_prior_i != `RCWE_PRI_PRIMARY); // RULE2
  wire [23:0] osc_len = (osc_mode_r == `RCWE_OSC_PLL) ?
                        START_CYC[23:0] + PLL_CYC[23:0] : START_CYC[23:0];

  // wake state machine
  always @* begin
    case (st_r)
      ST_RUN: st_nxt = wake_i ? ST_WAIT : ST_RUN;
      // both delays run in parallel RULE4
      ST_WAIT: st_nxt = (csd_cnt_r <= 24'h000001 &&
                         (!start_need_r || osc_cnt_r <= 24'h000001)) ?
                        ST_GO : ST_WAIT;
      ST_GO: st_nxt = ST_RUN;
      default: st_nxt = ST_RUN;
    endcase
  end

  // delay counters and status outputs RULE3
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r <= ST_RUN;
      csd_cnt_r <= 24'h000000;
      osc_cnt_r <= 24'h000000;
      start_need_r <= 1'b0;
      cpu_run_o <= 1'b1;
      primary_clock_ready_o <= 1'b0;
      internal_osc_stable_o <= 1'b0;
    end else if (dev_reset_o) begin
      st_r <= ST_RUN;
      cpu_run_o <= 1'b0;
    end else begin
      st_r <= st_nxt;
      case (st_r)
        ST_RUN: begin
          cpu_run_o <= ~wake_i & cpu_run_o | ~wake_i & ~sleep_instr_i;
          if (wake_i) begin
            csd_cnt_r <= CSD_CYC[23:0];
            osc_cnt_r <= osc_len;
            start_need_r <= start_need;
            cpu_run_o <= 1'b0;
            if (start_need) begin
              primary_clock_ready_o <= 1'b0;
            end
          end
        end
        ST_WAIT: begin
          if (csd_cnt_r != 24'h000000) begin
            csd_cnt_r <= csd_cnt_r - 24'h000001;
          end
          if (osc_cnt_r != 24'h000000) begin
            osc_cnt_r <= osc_cnt_r - 24'h000001;
          end
        end
        ST_GO: begin
          // execution starts on cycle after the delay RULE3
          cpu_run_o <= 1'b1;
          // readiness bit by target kind RULE6
          primary_clock_ready_o <= ~tgt_int;
          internal_osc_stable_o <= tgt_int;
        end
        default: cpu_run_o <= 1'b1;
      endcase
    end
  end
endmodule

// File: rcwe_pin_drv.sv
`timescale 1ns/10ps
// drives the reset pin low for a set number of cycles
module rcwe_pin_drv (
  // clock
  input wire clk_i,
  // pulse request
  input wire go_i,
  input wire [7:0] len_i,
  // pin level, pulled up when idle
  output wire pin_o
);
  reg [7:0] cnt_r = 8'h00;
  // load length on request, count down while low
  always @(posedge clk_i) begin
    if (go_i) begin
      cnt_r <= len_i;
    end else if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end
  assign pin_o = (cnt_r == 8'h00);
endmodule

// File: rcwe_top_properties.sv
`timescale 1ns/10ps
// port checks for reset causes, pin filter and wake timing
module rcwe_top_properties #(
  parameter FILT_CYC = 8
) (
  // clock, reset and straps
  input wire clk_i,
  input wire arst_n_i,
  input wire [1:0] brownout_mode_config_i,
  input wire master_reset_pin_enable_i,
  // events
  input wire master_reset_pin_i,
  input wire brownout_evt_i,
  input wire reset_instr_evt_i,
  input wire wake_i,
  input wire [1:0] wake_prior_i,
  // watched outputs
  input wire master_reset_pin_oe_o,
  input wire pin_digital_o,
  input wire dev_reset_o,
  input wire [3:0] reset_cause_o,
  input wire cpu_run_o,
  input wire brownout_enabled_o
);
  reg [7:0] lo_r;
  reg [11:0] run_lo_r;
  reg wk_r;
  reg [1:0] pri_r;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // pin low run length, halted run length, wake in flight
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lo_r <= 8'h00;
      run_lo_r <= 12'h000;
      wk_r <= 1'b0;
      pri_r <= 2'h0;
    end else begin
      lo_r <= master_reset_pin_i ? 8'h00 : lo_r + {7'h00, lo_r != 8'hFF};
      run_lo_r <= cpu_run_o ? 12'h000 : run_lo_r + 12'h001;
      if (wake_i && cpu_run_o) begin
        wk_r <= 1'b1;
        pri_r <= wake_prior_i;
      end else if (cpu_run_o) begin
        wk_r <= 1'b0;
      end
    end
  end
  sequence s_halt;
    !cpu_run_o [*8];
  endsequence
  sequence s_resume;
    $rose(cpu_run_o) && wk_r;
  endsequence
  property p_no_drive;
    !master_reset_pin_oe_o;
  endproperty
  a_no_drive: assert property (p_no_drive)
    else $error("reset pin driven");
  property p_halt;
    wake_i && cpu_run_o |=> s_halt;
  endproperty
  a_halt: assert property (p_halt)
    else $error("run not halted on wake");
  property p_idle;
    s_resume ##0 pri_r == 2'h0 |-> run_lo_r >= 39 && run_lo_r <= 61;
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle wake delay wrong");
  property p_min;
    s_resume |-> run_lo_r >= 39;
  endproperty
  a_min: assert property (p_min)
    else $error("wake delay too short");
  property p_filter;
    $rose(master_reset_pin_i) && lo_r < FILT_CYC |-> !dev_reset_o [*8];
  endproperty
  a_filter: assert property (p_filter)
    else $error("short pin pulse reset device");
  property p_pin_off;
    !master_reset_pin_enable_i |->
      !(dev_reset_o && reset_cause_o[3:1] == 3'h1);
  endproperty
  a_pin_off: assert property (p_pin_off)
    else $error("disabled pin caused reset");
  property p_digital;
    master_reset_pin_enable_i [*2] |-> pin_digital_o;
  endproperty
  a_digital: assert property (p_digital)
    else $error("digital input not idle high");
  property p_bo_soft;
    brownout_mode_config_i != 2'h1 |->
      brownout_enabled_o == (brownout_mode_config_i != 2'h0);
  endproperty
  a_bo_soft: assert property (p_bo_soft)
    else $error("brown-out enable wrong outside soft mode");
  property p_cause;
    brownout_evt_i || reset_instr_evt_i |=> dev_reset_o &&
      reset_cause_o == ($past(brownout_evt_i) ? 4'h5 : 4'h6);
  endproperty
  a_cause: assert property (p_cause)
    else $error("reset cause wrong");
endmodule
bind rcwe_top rcwe_top_properties #(.FILT_CYC(FILT_CYC)) u_props (
  .clk_i(clk_i), .arst_n_i(arst_n_i),
  .brownout_mode_config_i(brownout_mode_config_i),
  .master_reset_pin_enable_i(master_reset_pin_enable_i),
  .master_reset_pin_i(master_reset_pin_i),
  .brownout_evt_i(brownout_evt_i),
  .reset_instr_evt_i(reset_instr_evt_i), .wake_i(wake_i),
  .wake_prior_i(wake_prior_i),
  .master_reset_pin_oe_o(master_reset_pin_oe_o),
  .pin_digital_o(pin_digital_o), .dev_reset_o(dev_reset_o),
  .reset_cause_o(reset_cause_o), .cpu_run_o(cpu_run_o),
  .brownout_enabled_o(brownout_enabled_o));

// File: reset_cause_and_wake_exit_bench.sv
`timescale 1ns/10ps
`include "rcwe_defines.vh"
// self-checking bench for the reset cause and wake exit block
module reset_cause_and_wake_exit_bench;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [1:0] cfg = 2'h1, pri = 2'h0, br, rr;
  logic en = 1'b1, pm = 1'b0, wk = 1'b0, go = 1'b0;
  logic [7:0] ev = 8'h00, len = 8'h00;
  logic [3:0] aw = 4'h0, ar = 4'h0, cause;
  logic awv = 1'b0, wv = 1'b0, arv = 1'b0, bre = 1'b0, rre = 1'b0;
  logic [31:0] wd = 32'h0, rd;
  logic [2:0] ircf;
  logic pin, oe, dig, drst, run, prdy, irdy, irq_priority_enable, boen;
  logic awr, wr, arr, bv, rv;
  int fail_count = 0, comparisons = 0, cyc = 0;
  // 25 MHz clock
  always #20 clk_i = ~clk_i;
  rcwe_pin_drv drv (.clk_i(clk_i), .go_i(go), .len_i(len), .pin_o(pin));
  rcwe_top #(.FILT_CYC(4), .PLL_CYC(20)) uut (.clk_i(clk_i),
    .arst_n_i(arst_n_i), .brownout_mode_config_i(cfg),
    .master_reset_pin_enable_i(en), .master_reset_pin_i(pin),
    .brownout_evt_i(ev[0]), .wdt_reset_evt_i(ev[1]),
    .wdt_timeout_evt_i(ev[2]),
    .reset_instr_evt_i(ev[3]), .stack_full_evt_i(ev[4]),
    .stack_under_evt_i(ev[5]), .sleep_instr_i(ev[6]),
    .watchdog_clear_instr_i(ev[7]), .pm_mode_i(pm), .wake_i(wk),
    .wake_prior_i(pri), .master_reset_pin_o(), .master_reset_pin_oe_o(oe),
    .pin_digital_o(dig), .dev_reset_o(drst), .reset_cause_o(cause),
    .cpu_run_o(run), .primary_clock_ready_o(prdy),
    .internal_osc_stable_o(irdy), .irq_priority_enable_o(irq_priority_enable),
    .brownout_enabled_o(boen), .ircf_o(ircf), .s_axi_awaddr(aw),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
    .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rre));
  // verdict and end of run
  task complete_run;
    if (fail_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // bus write; ready and response seen at the negedge before the edge
  task wr_reg(input logic [3:0] a, input logic [7:0] d,
              output logic [1:0] r);
    @(posedge clk_i);
    aw <= a;
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    do @(negedge clk_i); while (!(awr && wr));
    @(posedge clk_i);
    awv <= 1'b0;
    wv <= 1'b0;
    do @(negedge clk_i); while (!bv);
    r = br;
    @(posedge clk_i);
    bre <= 1'b0;
  endtask
  task rd_reg(input logic [3:0] a, output logic [31:0] d,
              output logic [1:0] r);
    @(posedge clk_i);
    ar <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do @(negedge clk_i); while (!arr);
    @(posedge clk_i);
    arv <= 1'b0;
    do @(negedge clk_i); while (!rv);
    d = rd;
    r = rr;
    @(posedge clk_i);
    rre <= 1'b0;
  endtask
  task chk_reg(input logic [3:0] a, input logic [31:0] m, e);
    logic [31:0] d;
    logic [1:0] r;
    rd_reg(a, d, r);
    chk(d & m, e);
    chk(r, 32'h0);
  endtask
  task pulse(input int i);
    @(posedge clk_i);
    ev <= 8'h01 << i;
    @(posedge clk_i);
    ev <= 8'h00;
    @(negedge clk_i);
  endtask
  // reset values, access kinds and refused accesses
  task t_regs;
    logic [31:0] d;
    logic [1:0] r;
    chk_reg(`RCWE_ADDR_RCC, 32'hFFFFFFFF, 32'h5C);
    chk_reg(`RCWE_ADDR_CFG, 32'h70, 32'h40);
    chk(ircf, 32'h4);
    chk_reg(`RCWE_ADDR_STAT, 32'hF2, 32'h12);
    chk(boen, 32'h1);
    wr_reg(`RCWE_ADDR_RCC, 8'hFF, r);
    chk_reg(`RCWE_ADDR_RCC, 32'hFF, 32'hDF);
    chk(irq_priority_enable, 32'h1);
    wr_reg(`RCWE_ADDR_RCC, 8'h5F, r);
    chk(irq_priority_enable, 32'h0);
    @(posedge clk_i);
    cfg <= 2'h2;
    chk_reg(`RCWE_ADDR_RCC, 32'h40, 32'h0);
    chk(boen, 32'h1);
    @(posedge clk_i);
    cfg <= 2'h0;
    @(negedge clk_i);
    chk(boen, 32'h0);
    @(posedge clk_i);
    cfg <= 2'h1;
    rd_reg(4'hC, d, r);
    chk(r, 32'h2);
    wr_reg(`RCWE_ADDR_STAT, 8'h00, r);
    chk(r, 32'h2);
  endtask
  // sleep, time-out and clear instruction flags
  task t_flags;
    pulse(6);
    chk_reg(`RCWE_ADDR_RCC, 32'h0C, 32'h08);
    pulse(2);
    chk_reg(`RCWE_ADDR_RCC, 32'h0C, 32'h00);
    pulse(7);
    chk_reg(`RCWE_ADDR_RCC, 32'h0C, 32'h0C);
  endtask
  // exit delay for each prior clock and target kind
  task automatic t_wake;
    logic [1:0] p[5] = '{2'h0, 2'h3, 2'h1, 2'h2, 2'h1};
    logic [3:0] m[5] = '{4'h3, 4'h4, 4'h1, 4'h3, 4'h6};
    int lo[5] = '{45, 45, 1022, 1042, 45};
    int n;
    logic [1:0] r;
    for (int i = 0; i < 5; i++) begin
      wr_reg(`RCWE_ADDR_CFG, {4'h4, m[i]}, r);
      @(posedge clk_i);
      pri <= p[i];
      wk <= 1'b1;
      @(posedge clk_i);
      wk <= 1'b0;
      n = 0;
      @(negedge clk_i);
      while (!run) begin
        @(negedge clk_i);
        n++;
      end
      chk((n >= lo[i] && n <= lo[i] + 12) ? lo[i] : n, lo[i]);
      chk(m[i] == `RCWE_OSC_INT ? irdy : prdy, 32'h1);
    end
  endtask
  // pin pulse; expected cause 0 means no reset
  task pin_try(input logic [7:0] l, input logic p, e,
               input logic [3:0] c);
    logic seen, dl;
    logic [3:0] cs;
    seen = 1'b0;
    dl = 1'b0;
    cs = 4'h0;
    @(posedge clk_i);
    pm <= p;
    en <= e;
    len <= l;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    repeat (24) begin
      @(negedge clk_i);
      if (drst === 1'b1) begin
        seen = 1'b1;
        cs = cause;
      end
      if (dig === 1'b0) dl = 1'b1;
    end
    chk(cs, c);
    chk(dl, !e);
    chk(oe, 32'h0);
    @(posedge clk_i);
    en <= 1'b1;
  endtask
  // each internal reset event sets its cause; brown-out and reset instruction clear their flags
  task automatic t_causes;
    int idx[5] = '{0, 1, 3, 4, 5};
    logic [3:0] ex[5] = '{4'h5, 4'h4, 4'h6, 4'h7, 4'h8};
    for (int i = 0; i < 5; i++) begin
      pulse(idx[i]);
      chk(drst, 32'h1);
      chk(cause, ex[i]);
      repeat (4) @(posedge clk_i);
    end
    chk_reg(`RCWE_ADDR_RCC, 32'h13, 32'h02);
    chk_reg(`RCWE_ADDR_RCC, 32'h03, 32'h02);
  endtask
  // cut a hang short
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      complete_run;
    end
  end
  initial begin
    repeat (3) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    t_regs;
    t_flags;
    t_wake;
    pin_try(8'h03, 1'b0, 1'b1, 4'h0);
    pin_try(8'h04, 1'b0, 1'b1, 4'h2);
    pin_try(8'h0C, 1'b1, 1'b1, 4'h3);
    pin_try(8'h0C, 1'b0, 1'b0, 4'h0);
    t_causes;
    complete_run;
  end
endmodule
